// ---- bench/monitor_config_control_sva.sv ----
// Port-level checks for the global configuration register bank
`timescale 1ns/1ps
module monitor_config_control_sva
    import monitor_cfg_pkg::*;
(
    // Clock, reset and register port
    input wire logic              i_clk,
    input wire logic              i_nrst,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic              i_reg_wr,
    input wire logic              i_reg_rd,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic              o_reg_ack,
    // Control outputs and pins
    input wire logic              o_measure_en,
    input wire logic              o_events_masked,
    input wire logic              o_fan_auto_en,
    input wire logic              o_boost_en,
    input wire logic              o_pwm_force_zero,
    input wire logic              o_lock,
    input wire logic              o_alert_oe,
    input wire logic              i_cpu2_throttle_signal_in,
    input wire logic              o_cpu1_throttle_signal_oe,
    input wire logic              o_cpu2_throttle_signal_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic cfg_wr;  // Write aimed at the configuration register
    assign cfg_wr = i_reg_wr && (i_reg_addr == GLOBAL_CONFIGURATION_ADDR);
    AST_BASIC_MODE: assert property (!o_fan_auto_en |-> o_events_masked && o_pwm_force_zero && !o_boost_en)
        else $error("basic mode outputs wrong");
    AST_FULL_MODE: assert property (o_fan_auto_en |-> o_boost_en && !o_pwm_force_zero)
        else $error("full mode outputs wrong");
    AST_START_WR: assert property (cfg_wr && i_reg_wdata[START_BIT] && !o_lock |=> o_fan_auto_en)
        else $error("start write had no effect");
    AST_MEASURE: assert property (o_measure_en)
        else $error("measurement stopped");
    AST_LOCK_STICKY: assert property (o_lock |=> o_lock)
        else $error("lock dropped without reset");
    AST_LOCK_FREEZE: assert property (o_lock |=> $stable(o_fan_auto_en))
        else $error("start moved while locked");
    AST_GMASK: assert property (cfg_wr && i_reg_wdata[GMASK_BIT] |=> o_events_masked)
        else $error("global mask ignored");
    AST_ACK: assert property (1'b1 |=> (o_reg_ack == $past(i_reg_wr || i_reg_rd)))
        else $error("ack not one cycle after strobe");
    AST_MASKED_QUIET: assert property (o_events_masked |=> !o_alert_oe)
        else $error("alert while events masked");
    AST_TIE_CAUSE: assert property (o_cpu1_throttle_signal_oe |->
        $past(!i_cpu2_throttle_signal_in && !o_cpu2_throttle_signal_oe))
        else $error("throttle pin driven without cause");
endmodule
bind monitor_config_control monitor_config_control_sva chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_ack(o_reg_ack),
    .o_measure_en(o_measure_en), .o_events_masked(o_events_masked), .o_fan_auto_en(o_fan_auto_en),
    .o_boost_en(o_boost_en), .o_pwm_force_zero(o_pwm_force_zero), .o_lock(o_lock), .o_alert_oe(o_alert_oe),
    .i_cpu2_throttle_signal_in(i_cpu2_throttle_signal_in), .o_cpu1_throttle_signal_oe(o_cpu1_throttle_signal_oe),
    .o_cpu2_throttle_signal_oe(o_cpu2_throttle_signal_oe));

// ---- bench/tb.sv ----
// Self-checking bench for the global configuration register bank
`timescale 1ns/1ps
module tb;
    import monitor_cfg_pkg::*;
    logic              i_clk, nrst, reg_wr, reg_rd, ack, round_done, bmc_err;  // Clock, reset, strobes
    logic [ADDR_W-1:0] reg_addr;                                               // Register address
    logic [DATA_W-1:0] wdata, rdata;                                           // Register data
    logic              measure_en, ev_masked, fan_auto, boost, pwm_zero, lock; // Control outputs
    logic [THERM_W-1:0] th_live, th_mask;                                      // Thermal sources
    logic              alert_out, alert_oe, pin1, pin2, out1, out2, oe1, oe2;  // Pins
    logic              ext1_low, ext2_low;                                     // Other agent on pins
    int                n_fail, n_checks, cyc;                                  // Counters
    monitor_config_control uut (.i_clk(i_clk), .i_nrst(nrst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack), .i_round_done(round_done),
        .o_measure_en(measure_en), .o_events_masked(ev_masked), .o_fan_auto_en(fan_auto), .o_boost_en(boost),
        .o_pwm_force_zero(pwm_zero), .o_lock(lock), .i_bmc_err_any(bmc_err), .i_thermal_live(th_live),
        .i_thermal_mask(th_mask), .o_alert_out(alert_out), .o_alert_oe(alert_oe), .i_cpu1_throttle_signal_in(pin1),
        .o_cpu1_throttle_signal_out(out1), .o_cpu1_throttle_signal_oe(oe1), .i_cpu2_throttle_signal_in(pin2),
        .o_cpu2_throttle_signal_out(out2), .o_cpu2_throttle_signal_oe(oe2));
    throttle_pins_model pins (.i_dev1_oe(oe1), .i_dev2_oe(oe2), .i_ext1_low(ext1_low), .i_ext2_low(ext2_low),
        .o_pin1(pin1), .o_pin2(pin2));
    // Free-running clock
    initial begin
        i_clk = 0;
        forever #10 i_clk = ~i_clk;
    end
    // Hang guard, far above the fifty or so cycles the run needs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Let n edges pass, then settle just after the last
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    // One register cycle; strobe is a single-cycle pulse, a spare cycle keeps drivers apart
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        wait_cycles(1);
        reg_wr = 0;
        reg_rd = 0;
        check(ack, 1);
        wait_cycles(1);
    endtask
    task automatic s_reset_state();
        check(ev_masked, 1);
        check(pwm_zero, 1);
        check(fan_auto, 0);
        check(alert_out, DRIVE_LEVEL);
        check(out1, DRIVE_LEVEL);
        check(out2, DRIVE_LEVEL);
        access(0, GLOBAL_CONFIGURATION_ADDR, 0);
        check(rdata, CFG_RESET);
    endtask
    task automatic s_start_mask();
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h01);
        check(fan_auto, 1);
        check(boost, 1);
        check(pwm_zero, 0);
        check(ev_masked, 0);
        check(measure_en, 1);
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h05);
        check(ev_masked, 1);
        check(fan_auto, 1);
        // Every writable bit but lock, so later scenarios start unlocked
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'hfd);
        access(1, 8'he4, 8'hff);
        access(0, 8'he4, 0);
        check(rdata, UNMAPPED_DATA);
        access(0, GLOBAL_CONFIGURATION_ADDR, 0);
        check(rdata, 8'h7d);
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h00);
        check(pwm_zero, 1);
    endtask
    task automatic s_alert();
        bmc_err = 1;
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h09);
        check(alert_oe, 1);
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h01);
        check(alert_oe, 0);
        th_live = 6'h01;
        th_mask = 6'h01;
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h29);
        check(alert_oe, 0);
        th_mask = 6'h00;
        wait_cycles(1);
        check(alert_oe, 1);
        th_live = 6'h00;
        wait_cycles(1);
        check(alert_oe, 0);
        th_live = 6'h20;
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h2d);
        check(alert_oe, 0);
        bmc_err = 0;
        th_live = 6'h00;
    endtask
    task automatic s_tie();
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h10);
        ext1_low = 1;
        wait_cycles(1);
        check(oe2, 1);
        check(oe1, 0);
        ext1_low = 0;
        wait_cycles(1);
        check(oe2, 0);
        ext2_low = 1;
        wait_cycles(1);
        check(oe1, 1);
        ext2_low = 0;
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h00);
        ext1_low = 1;
        wait_cycles(1);
        check(oe2, 0);
        ext1_low = 0;
    endtask
    task automatic s_lock();
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h03);
        check(lock, 1);
        access(1, GLOBAL_CONFIGURATION_ADDR, 8'h08);
        access(0, GLOBAL_CONFIGURATION_ADDR, 0);
        check(rdata, 8'h0b);
        check(fan_auto, 1);
        nrst = 0;
        wait_cycles(2);
        nrst = 1;
        check(lock, 0);
        check(fan_auto, 0);
        check(ev_masked, 1);
    endtask
    task automatic s_ready();
        round_done = 1;
        wait_cycles(1);
        round_done = 0;
        access(0, GLOBAL_CONFIGURATION_ADDR, 0);
        check(rdata, 8'h80);
    endtask
    // Main sequence
    initial begin
        {nrst, reg_wr, reg_rd, round_done, bmc_err, ext1_low, ext2_low} = '0;
        {reg_addr, wdata, th_live, th_mask} = '0;
        {n_fail, n_checks, cyc} = '0;
        wait_cycles(6);
        nrst = 1;
        s_reset_state();
        s_start_mask();
        s_alert();
        s_tie();
        s_lock();
        s_ready();
        summarize();
    end
endmodule

// ---- bench/throttle_pins_model.sv ----
// Board model of the two open-drain processor throttle pins
`timescale 1ns/1ps
module throttle_pins_model (
    // Device pin enables
    input  wire logic i_dev1_oe,
    input  wire logic i_dev2_oe,
    // Another board agent pulling a pin low
    input  wire logic i_ext1_low,
    input  wire logic i_ext2_low,
    // Resolved wire levels
    output logic      o_pin1,
    output logic      o_pin2
);
    // Pull-ups win unless a party drives; pins kept apart on the board
    assign o_pin1 = !(i_dev1_oe || i_ext1_low);
    assign o_pin2 = !(i_dev2_oe || i_ext2_low);
endmodule

// ---- core/alert_throttle_unit.sv ----
// Alert pin and processor throttle pin logic driven by the configuration fields
`timescale 1ns/1ps
module alert_throttle_unit
    import monitor_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    // Configuration
    cfg_bus_if.unit                    cfg,
    // Error sources
    input  wire logic                  i_bmc_err_any,
    input  wire logic [THERM_W-1:0]    i_thermal_live,
    input  wire logic [THERM_W-1:0]    i_thermal_mask,
    // Throttle pin levels as seen on the wire
    input  wire logic [THROTTLE_N-1:0] i_throttle_in,
    // Pin enables
    output logic                       o_alert_oe,
    output logic [THROTTLE_N-1:0]      o_throttle_oe
);
    import monitor_cfg_pkg::*;

    logic                  alert_d;  // Next alert drive
    logic                  alert_q;  // Alert drive flop
    logic [THROTTLE_N-1:0] thr_d;    // Next throttle drives
    logic [THROTTLE_N-1:0] thr_q;    // Throttle drive flops
    logic                  therm_hit; // Any unmasked live thermal condition

    // Alert source selection
    always_comb begin
        therm_hit = |(i_thermal_live & ~i_thermal_mask);
        if (!cfg.alert_en || cfg.events_masked) begin
            // Disabled pin or globally masked events never assert
            alert_d = 1'b0;
        end else if (cfg.comp_mode) begin
            // Follows the live condition, so it drops when it ends
            alert_d = therm_hit;
        end else begin
            // Any latched management error holds the pin
            alert_d = i_bmc_err_any;
        end
    end

    // Throttle tie: each pin copies the other pin when someone else pulls it.
    // Our own drive on the other pin is excluded, otherwise the pair would
    // hold itself low forever once joined.
    genvar g;
    generate
        for (g = 0; g < THROTTLE_N; g++) begin : g_thr
            always_comb begin
                thr_d[g] = cfg.tie && !i_throttle_in[THROTTLE_N-1-g]
                           && !thr_q[THROTTLE_N-1-g];
            end
        end
    endgenerate

    // Register the pin enables
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            alert_q <= 1'b0;
            thr_q   <= '0;
        end else begin
            alert_q <= alert_d;
            thr_q   <= thr_d;
        end
    end

    assign o_alert_oe    = alert_q;
    assign o_throttle_oe = thr_q;
endmodule

// ---- core/monitor_config_control.sv ----
// Global configuration register bank of the hardware monitor
//
// Behaviour
// - Start clear: events masked, auto fan off
// - Start clear: both fan outputs at zero
// - Measurement keeps running whatever start holds
// - Start set: unmask events, auto fan, boost
// - Lock freezes all lockable bits, start too
// - Lock clears only by external reset
// - Global mask masks events, nothing else changes
// - Alert enable bit gates the alert pin
// - Tie bit joins the two throttle pins
// - Comparator mode alerts unmasked thermal events only
// - Comparator alert drops when condition ends
// - Ready sets after all channels measured
// - Alert asserts on any management error bit, outside comparator mode
`timescale 1ns/1ps
module monitor_config_control
    import monitor_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_nrst,
    // Register access port from the serial slave
    input  wire logic [monitor_cfg_pkg::ADDR_W-1:0] i_reg_addr,
    input  wire logic                            i_reg_wr,
    input  wire logic                            i_reg_rd,
    input  wire logic [monitor_cfg_pkg::DATA_W-1:0] i_reg_wdata,
    output logic      [monitor_cfg_pkg::DATA_W-1:0] o_reg_rdata,
    output logic                                 o_reg_ack,
    // Measurement engine
    input  wire logic                            i_round_done,
    output logic                                 o_measure_en,
    // Control outputs to the rest of the monitor
    output logic                                 o_events_masked,
    output logic                                 o_fan_auto_en,
    output logic                                 o_boost_en,
    output logic                                 o_pwm_force_zero,
    output logic                                 o_lock,
    // Error sources for the alert pin
    input  wire logic                            i_bmc_err_any,
    input  wire logic [monitor_cfg_pkg::THERM_W-1:0] i_thermal_live,
    input  wire logic [monitor_cfg_pkg::THERM_W-1:0] i_thermal_mask,
    // Alert pin, open drain
    output logic                                 o_alert_out,
    output logic                                 o_alert_oe,
    // Processor throttle pins, open drain
    input  wire logic                            i_cpu1_throttle_signal_in,
    output logic                                 o_cpu1_throttle_signal_out,
    output logic                                 o_cpu1_throttle_signal_oe,
    input  wire logic                            i_cpu2_throttle_signal_in,
    output logic                                 o_cpu2_throttle_signal_out,
    output logic                                 o_cpu2_throttle_signal_oe
);
    import monitor_cfg_pkg::*;

    // Address decode shared by the read and write paths
    function automatic logic cfg_hit(input logic [ADDR_W-1:0] addr);
        cfg_hit = (addr == GLOBAL_CONFIGURATION_ADDR);
    endfunction

    // Register state
    logic [DATA_W-1:0] cfg_q;     // Writable fields, ready slot kept zero
    logic [DATA_W-1:0] cfg_d;     // Next writable fields
    logic              ready_q;   // First full round collected
    logic              ready_d;   // Next ready
    logic [DATA_W-1:0] rdata_q;   // Read data flop
    logic [DATA_W-1:0] rdata_d;   // Next read data
    logic              ack_q;     // Access acknowledge
    logic              ack_d;     // Next acknowledge

    // Derived control flops
    logic              masked_q;  // Global event mask in force
    logic              masked_d;
    logic              fan_q;     // Auto fan and boost allowed
    logic              fan_d;
    logic              pwm0_q;    // Force fans to zero duty
    logic              pwm0_d;
    logic              meas_q;    // Measurement enable
    logic              meas_d;

    // Open-drain drive values
    logic              alert_out_q;
    logic [1:0]        thr_out_q;

    // Fields handed to the pin unit
    cfg_bus_if cfg_if ();

    // Write path with lock protection
    always_comb begin
        logic [DATA_W-1:0] keep_mask;
        keep_mask = '0;
        cfg_d     = cfg_q;
        if (i_reg_wr && cfg_hit(i_reg_addr)) begin
            // Bits frozen by the lock keep their old value; no error shown
            keep_mask = cfg_q[LOCK_BIT] ? CFG_LOCK_MASK : '0;
            cfg_d = (cfg_q & (keep_mask | ~CFG_WRITE_MASK))
                  | (i_reg_wdata & CFG_WRITE_MASK & ~keep_mask);
        end
        // Once locked, only reset clears the lock
        if (cfg_q[LOCK_BIT]) begin
            cfg_d[LOCK_BIT] = 1'b1;
        end
    end

    // Ready flag: set by hardware, software cannot clear it
    always_comb begin
        ready_d = ready_q | i_round_done;
    end

    // Read path and acknowledge
    always_comb begin
        rdata_d = rdata_q;
        ack_d   = i_reg_wr | i_reg_rd;
        if (i_reg_rd) begin
            if (cfg_hit(i_reg_addr)) begin
                // Ready lives in its own flop and is merged here
                rdata_d = cfg_q;
                rdata_d[READY_BIT] = ready_q;
            end else begin
                // Unmapped addresses answer zero
                rdata_d = UNMAPPED_DATA;
            end
        end
    end

    // Control outputs follow the next register value, so they move on the
    // same edge as the field itself rather than one cycle late
    always_comb begin
        masked_d = !cfg_d[START_BIT] || cfg_d[GMASK_BIT];
        fan_d    = cfg_d[START_BIT];
        pwm0_d   = !cfg_d[START_BIT];
        meas_d   = 1'b1;
    end

    // Register all state
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            // External reset is the only way out of lock
            cfg_q       <= CFG_RESET;
            ready_q     <= 1'b0;
            rdata_q     <= '0;
            ack_q       <= 1'b0;
            masked_q    <= 1'b1;
            fan_q       <= 1'b0;
            pwm0_q      <= 1'b1;
            meas_q      <= 1'b1;
            alert_out_q <= DRIVE_LEVEL;
            thr_out_q   <= {2{DRIVE_LEVEL}};
        end else begin
            cfg_q       <= cfg_d;
            ready_q     <= ready_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
            masked_q    <= masked_d;
            fan_q       <= fan_d;
            pwm0_q      <= pwm0_d;
            meas_q      <= meas_d;
            alert_out_q <= DRIVE_LEVEL;
            thr_out_q   <= {2{DRIVE_LEVEL}};
        end
    end

    // Hand the stored fields to the pin unit
    assign cfg_if.start         = cfg_q[START_BIT];
    assign cfg_if.events_masked = masked_q;
    assign cfg_if.alert_en      = cfg_q[ALERT_EN_BIT];
    assign cfg_if.comp_mode     = cfg_q[COMP_BIT];
    assign cfg_if.tie           = cfg_q[TIE_BIT];

    // Pin enables for alert and throttle lines
    logic [1:0] thr_oe;  // Throttle enables from the unit

    alert_throttle_unit u_pins (
        .i_clk          (i_clk),
        .i_nrst         (i_nrst),
        .cfg            (cfg_if),
        .i_bmc_err_any  (i_bmc_err_any),
        .i_thermal_live (i_thermal_live),
        .i_thermal_mask (i_thermal_mask),
        .i_throttle_in  ({i_cpu2_throttle_signal_in, i_cpu1_throttle_signal_in}),
        .o_alert_oe     (o_alert_oe),
        .o_throttle_oe  (thr_oe)
    );

    // Outputs, all from flops
    assign o_reg_rdata                = rdata_q;
    assign o_reg_ack                  = ack_q;
    assign o_measure_en               = meas_q;
    assign o_events_masked            = masked_q;
    assign o_fan_auto_en              = fan_q;
    assign o_boost_en                 = fan_q;
    assign o_pwm_force_zero           = pwm0_q;
    assign o_lock                     = cfg_q[LOCK_BIT];
    assign o_alert_out                = alert_out_q;
    assign o_cpu1_throttle_signal_out = thr_out_q[0];
    assign o_cpu1_throttle_signal_oe  = thr_oe[0];
    assign o_cpu2_throttle_signal_out = thr_out_q[1];
    assign o_cpu2_throttle_signal_oe  = thr_oe[1];
endmodule

// ---- pkg/cfg_bus_if.sv ----
// Configuration fields passed from the register bank to the alert and throttle unit
`timescale 1ns/1ps
interface cfg_bus_if;
    logic start;          // Full operation enabled
    logic events_masked;  // All error events masked
    logic alert_en;       // Alert pin enabled
    logic comp_mode;      // Thermal comparator alert mode
    logic tie;            // Throttle pins joined

    // Register bank drives the fields
    modport ctrl (
        output start,
        output events_masked,
        output alert_en,
        output comp_mode,
        output tie
    );

    // Unit consumes them
    modport unit (
        input start,
        input events_masked,
        input alert_en,
        input comp_mode,
        input tie
    );
endinterface

// ---- pkg/monitor_cfg_pkg.sv ----
// Shared constants for the monitor global configuration register
package monitor_cfg_pkg;
    // Register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register address of the global configuration register
    localparam logic [ADDR_W-1:0] GLOBAL_CONFIGURATION_ADDR = 8'he3;

    // Field positions inside the global configuration register
    localparam int unsigned START_BIT      = 0;
    localparam int unsigned LOCK_BIT       = 1;
    localparam int unsigned GMASK_BIT      = 2;
    localparam int unsigned ALERT_EN_BIT   = 3;
    localparam int unsigned TIE_BIT        = 4;
    localparam int unsigned COMP_BIT       = 5;
    localparam int unsigned SPARE_BIT      = 6;
    localparam int unsigned READY_BIT      = 7;

    // Reset value and access masks
    localparam logic [DATA_W-1:0] CFG_RESET      = 8'h00;
    localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 8'h7f;  // Ready is read only
    localparam logic [DATA_W-1:0] CFG_LOCK_MASK  = 8'h03;  // Start and lock freeze
    localparam logic [DATA_W-1:0] UNMAPPED_DATA  = 8'h00;

    // Thermal comparator channel count and throttle pin count
    localparam int unsigned THERM_W    = 6;
    localparam int unsigned THROTTLE_N = 2;

    // Level driven onto an open-drain pin while its enable is high
    localparam logic DRIVE_LEVEL = 1'b0;
endpackage
